// file: include/pmr_pkg.sv
// Package with constants and carrier types for the power-mode and reset sequencer
package pmr_pkg;
   // Machine cycle of four clock states
   localparam int          STATES_PER_CYCLE = 4;
   localparam logic [1:0]  STATE_C4         = 2'h3;
   // Reset hold: two machine cycles
   localparam int          RESET_HOLD_CYC   = 2;
   // Watchdog grace time after time-out, in clock periods
   localparam int          WDT_GRACE_CLKS   = 512;
   // Power-on delay in clock periods
   localparam int          POR_DELAY_CLKS   = 16;
   // Power control bit positions
   localparam int          POWER_CONTROL_REG_IDLE        = 0;
   localparam int          POWER_CONTROL_REG_PDOWN       = 1;
   // Auxiliary control: software reset bit
   localparam int          AUX_SOFTWARE_RESET_BIT         = 3;
   // Watchdog control bit positions
   localparam int          WDC_WDIF         = 3;
   localparam int          WDC_WATCHDOG_RESET_FLAG         = 2;
   localparam int          WDC_WATCHDOG_RESET_ENABLE        = 1;
   // Reset values
   localparam logic [15:0] PC_RESET         = 16'h0000;
   localparam logic [7:0]  SP_RESET         = 8'h07;
   localparam logic [7:0]  PORT_HIGH        = 8'hff;
   localparam logic [7:0]  PORT_LOW         = 8'h00;
   localparam logic [7:0]  WDC_WDT_RESET    = 8'h04;
   localparam logic [7:0]  WDC_POR_RESET    = 8'h00;
   localparam logic [7:0]  WDC_EXT_KEEP     = 8'h06;

   // Wake-up sources from outside the block
   typedef struct packed {
      logic extInt0;
      logic extInt1;
      logic keypad;
      logic brownout;
      logic cmpOne;
      logic cmpTwo;
   } wake_s;

   // Enables and trigger modes for the external interrupts
   typedef struct packed {
      logic globalEn;
      logic int0En;
      logic int1En;
      logic int0Level;
      logic int1Level;
      logic anyEnabled;
   } irq_cfg_s;

   // Source of the most recent reset
   typedef enum logic [3:0] {
      SRC_NONE = 4'h0,
      SRC_EXT  = 4'h1,
      SRC_WDT  = 4'h2,
      SRC_POR  = 4'h4,
      SRC_SW   = 4'h8
   } reset_src_e;
endpackage

// file: core/power_mode_reset_ctrl.sv
// Power-mode and reset sequencer of an 8-bit microcontroller core
//
// How it works
// - Writing idle bit finishes current instruction, then enters idle.
// - Idle gates only the processor clock; peripherals keep running, state kept.
// - Enabled interrupt in idle clears idle bit, services, resumes after idle.
// - Reset in idle loads PC 0000h; next instruction never runs.
// - Watchdog counts in idle; reset follows 512 clocks after time-out.
// - Writing power-down bit finishes instruction then stops all clocks.
// - Reset pin low in power-down ends it and restarts at 0000h.
// - Power-down with external watchdog clock: watchdog does not count.
// - Power-down wake sources: ext ints, keypad, brownout, comparators, watchdog if cfg 0.
// - External pin wakes only if enabled, global enable set, level mode.
// - Power-down with low-power brownout and brownout enabled runs internal RC.
// - Reset pin sampled at C4 each machine cycle, applied synchronously.
// - Reset held while pin low, plus two machine cycles, then 0000h.
// - Power-up sets power-on flag at the start of the delay; software clears it.
// - Watchdog time-out sets flag; reset after 512 clocks if enabled.
// - Software reset bit resets the chip like hardware reset.
// - Reset holds PC at 0000h and stack pointer at 07h.
// - Reset masks wake interrupt in power-down only, disables watchdog on power-on, ports FFh if option.
// - Watchdog control loaded per reset source.
// - Watchdog reset sets the watchdog-reset flag; power-on clears it.
// - Power-on clears watchdog-reset-enable; other resets keep it.
`timescale 1ns/10ps
`default_nettype none
module power_mode_reset_ctrl #(
   parameter int HOLD_CYC = pmr_pkg::RESET_HOLD_CYC,
   parameter int GRACE    = pmr_pkg::WDT_GRACE_CLKS,
   parameter int POR_DLY  = pmr_pkg::POR_DELAY_CLKS
) (
   // Clock and power-on reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Pins from outside
   input  wire logic              resetPin_b,
   input  wire pmr_pkg::wake_s    wakePins,
   // Core handshake
   input  wire logic              instrEnd,
   input  wire logic              intTaken,
   input  wire logic              retiDone,
   // Software writes to control bits
   input  wire logic              pconWrite,
   input  wire logic [7:0]        pconData,
   input  wire logic              auxWrite,
   input  wire logic [7:0]        auxData,
   input  wire logic              porFlagClear,
   input  wire logic              wdtClear,
   input  wire logic              wdifClear,
   input  wire logic              ewrstWrite,
   input  wire logic              ewrstData,
   // Configuration levels
   input  wire pmr_pkg::irq_cfg_s irqCfg,
   input  wire logic              watchdog_config_bit,
   input  wire logic              wdtExtClock,
   input  wire logic              low_power_brownout_sel,
   input  wire logic              brownout_disable_bit,
   input  wire logic              reset_port_high_option,
   input  wire logic              wdtTimeout,
   // Clock gating and reset outputs
   output logic                   cpuClkEn,
   output logic                   periphClkEn,
   output logic                   rcClkSel,
   output logic                   coreReset,
   output logic                   wdtRun,
   output logic                   wakeIrq,
   // Register images
   output logic [7:0]             power_control_reg,
   output logic [7:0]             watchdog_control_reg,
   output logic                   porFlag,
   output logic [15:0]            pcLoad,
   output logic [7:0]             stack_pointer,
   output logic [7:0]             portReset,
   output logic [7:0]             port0_input_disable_reg,
   output pmr_pkg::reset_src_e    lastSource
);
   // Elaboration check
   if (HOLD_CYC < 1 || GRACE < 1 || POR_DLY < 1 || GRACE > 1024 || POR_DLY > 256
       || HOLD_CYC * pmr_pkg::STATES_PER_CYCLE > 255) begin : g_bad
      $error("Counts out of range for the counters");
   end
   typedef enum logic [2:0] {
      RUN   = 3'b001,
      IDLE  = 3'b010,
      PDOWN = 3'b100
   } mode_e;
   localparam int HOLD_CLKS = HOLD_CYC * pmr_pkg::STATES_PER_CYCLE;
   mode_e       mode;
   logic        pinSync1;
   logic        pinSync2;
   pmr_pkg::wake_s wakeSync1;
   pmr_pkg::wake_s wakeSync2;
   logic [1:0]  phase;
   logic        extReq;
   logic [9:0]  graceCnt;
   logic        graceRun;
   logic        wdtFire;
   logic [7:0]  holdCnt;
   logic [7:0]  porCnt;
   logic        porBusy;
   logic        swReq;
   logic        anyReset;
   logic        pendIdle;
   logic        pendDown;
   logic        extWake;
   logic        pdWake;
   logic        idleWake;

   // Two-stage synchroniser for the reset pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinSync1 <= 1'b1;
         pinSync2 <= 1'b1;
         wakeSync1 <= '0;
         wakeSync2 <= '0;
      end else begin
         pinSync1 <= resetPin_b;
         pinSync2 <= pinSync1;
         wakeSync1 <= wakePins;
         wakeSync2 <= wakeSync1;
      end
   end

   // Machine cycle state counter C1..C4, runs even in power-down for sampling
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // Reset pin sampled at C4 only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         extReq <= 1'b0;
      end else if (phase == pmr_pkg::STATE_C4) begin
         extReq <= !pinSync2;
      end
   end

   // Software reset request
   assign swReq = auxWrite && auxData[pmr_pkg::AUX_SOFTWARE_RESET_BIT];

   // Watchdog grace counter after time-out
   assign wdtRun = periphClkEn && !(mode == PDOWN && wdtExtClock);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         graceRun <= 1'b0;
         graceCnt <= 10'h000;
      end else if (anyReset || wdtClear) begin
         graceRun <= 1'b0;
         graceCnt <= 10'h000;
      end else if (wdtTimeout && wdtRun && !graceRun) begin
         graceRun <= 1'b1;
         graceCnt <= 10'h000;
      end else if (graceRun && wdtRun) begin
         graceRun <= (graceCnt != 10'(GRACE - 1));
         graceCnt <= graceCnt + 10'h001;
      end
   end
   assign wdtFire = graceRun && wdtRun && (graceCnt == 10'(GRACE - 1))
                    && watchdog_control_reg[pmr_pkg::WDC_WATCHDOG_RESET_ENABLE];

   assign anyReset = extReq || swReq || wdtFire || porBusy;

   // Power-on delay
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         porBusy <= 1'b1;
         porCnt  <= 8'h00;
      end else if (porBusy) begin
         porCnt <= porCnt + 8'h01;
         if (porCnt == 8'(POR_DLY - 1)) begin
            porBusy <= 1'b0;
         end
      end
   end

   // Internal reset held during request plus two machine cycles
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         coreReset <= 1'b1;
         holdCnt   <= 8'h00;
      end else if (anyReset) begin
         coreReset <= 1'b1;
         holdCnt   <= 8'(HOLD_CLKS);
      end else if (holdCnt != 8'h00) begin
         holdCnt <= holdCnt - 8'h01;
      end else begin
         coreReset <= 1'b0;
      end
   end

   // Wake-up qualification
   assign extWake = (wakeSync2.extInt0 && irqCfg.int0En && irqCfg.int0Level
                    || wakeSync2.extInt1 && irqCfg.int1En && irqCfg.int1Level)
                    && irqCfg.globalEn;
   assign pdWake = extWake || wakeSync2.keypad || wakeSync2.brownout
                   || wakeSync2.cmpOne || wakeSync2.cmpTwo
                   || (wdtTimeout && !watchdog_config_bit);
   assign idleWake = irqCfg.anyEnabled || (wdtTimeout && irqCfg.globalEn);

   // Pending mode requests wait for the writing instruction to end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pendIdle <= 1'b0;
         pendDown <= 1'b0;
      end else if (anyReset || instrEnd) begin
         pendIdle <= 1'b0;
         pendDown <= 1'b0;
      end else if (pconWrite) begin
         pendDown <= pconData[pmr_pkg::POWER_CONTROL_REG_PDOWN];
         pendIdle <= pconData[pmr_pkg::POWER_CONTROL_REG_IDLE] && !pconData[pmr_pkg::POWER_CONTROL_REG_PDOWN];
      end
   end

   // Mode machine
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode <= RUN;
      end else if (anyReset) begin
         mode <= RUN;
      end else begin
         case (mode)
            RUN: begin
               if (instrEnd && (pendDown || (pconWrite && pconData[pmr_pkg::POWER_CONTROL_REG_PDOWN]))) begin
                  mode <= PDOWN;
               end else if (instrEnd && (pendIdle || (pconWrite && pconData[pmr_pkg::POWER_CONTROL_REG_IDLE]))) begin
                  mode <= IDLE;
               end
            end
            IDLE: begin
               if (idleWake) begin
                  mode <= RUN;
               end
            end
            PDOWN: begin
               if (pdWake) begin
                  mode <= RUN;
               end
            end
            default: mode <= RUN;
         endcase
      end
   end

   // Clock gating outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpuClkEn    <= 1'b1;
         periphClkEn <= 1'b1;
         rcClkSel    <= 1'b0;
         wakeIrq     <= 1'b0;
      end else begin
         cpuClkEn    <= (mode == RUN) || anyReset;
         periphClkEn <= (mode != PDOWN) || anyReset;
         rcClkSel    <= (mode == PDOWN) && low_power_brownout_sel
                        && !brownout_disable_bit;
         wakeIrq     <= (mode == IDLE && idleWake) || (mode == PDOWN && pdWake && !anyReset);
      end
   end

   // Power control register image
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_control_reg <= 8'h00;
      end else if (anyReset) begin
         power_control_reg <= 8'h00;
      end else if (pconWrite) begin
         power_control_reg <= pconData;
      end else if (mode == IDLE && idleWake) begin
         power_control_reg[pmr_pkg::POWER_CONTROL_REG_IDLE] <= 1'b0;
      end else if (mode == PDOWN && pdWake) begin
         power_control_reg[pmr_pkg::POWER_CONTROL_REG_PDOWN] <= 1'b0;
      end
   end

   // Watchdog control by reset source; set wins over clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_control_reg <= pmr_pkg::WDC_POR_RESET;
      end else if (porBusy) begin
         watchdog_control_reg <= pmr_pkg::WDC_POR_RESET;
      end else if (wdtFire) begin
         watchdog_control_reg <= pmr_pkg::WDC_WDT_RESET
                                 | (watchdog_control_reg & 8'h02);
      end else if (extReq || swReq) begin
         watchdog_control_reg <= watchdog_control_reg & pmr_pkg::WDC_EXT_KEEP;
      end else begin
         if (ewrstWrite) begin
            watchdog_control_reg[pmr_pkg::WDC_WATCHDOG_RESET_ENABLE] <= ewrstData;
         end
         if (wdtTimeout && wdtRun) begin
            watchdog_control_reg[pmr_pkg::WDC_WDIF] <= 1'b1;
         end else if (wdifClear) begin
            watchdog_control_reg[pmr_pkg::WDC_WDIF] <= 1'b0;
         end
      end
   end

   // Power-on flag; set wins over clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         porFlag <= 1'b0;
      end else if (porBusy) begin
         porFlag <= 1'b1;
      end else if (porFlagClear) begin
         porFlag <= 1'b0;
      end
   end

   // Register reset images and last source
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pcLoad                  <= pmr_pkg::PC_RESET;
         stack_pointer           <= pmr_pkg::SP_RESET;
         portReset               <= pmr_pkg::PORT_LOW;
         port0_input_disable_reg <= pmr_pkg::PORT_LOW;
         lastSource              <= pmr_pkg::SRC_POR;
      end else if (anyReset) begin
         pcLoad                  <= pmr_pkg::PC_RESET;
         stack_pointer           <= pmr_pkg::SP_RESET;
         portReset               <= reset_port_high_option ? pmr_pkg::PORT_HIGH
                                                           : pmr_pkg::PORT_LOW;
         port0_input_disable_reg <= pmr_pkg::PORT_LOW;
         lastSource <= porBusy ? pmr_pkg::SRC_POR : wdtFire ? pmr_pkg::SRC_WDT
                     : swReq ? pmr_pkg::SRC_SW : pmr_pkg::SRC_EXT;
      end
   end

   // Assertions
   idle_gates_cpu_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == IDLE && !anyReset) |=> !cpuClkEn && periphClkEn)
      else $error("Idle does not gate only cpu clock");
   pdown_stops_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == PDOWN && !anyReset) |=> !periphClkEn)
      else $error("Power-down did not stop clocks");
   both_bits_pd_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == RUN && pconWrite && pconData[1:0] == 2'h3 && instrEnd && !anyReset)
      |=> mode == PDOWN)
      else $error("Both bits did not enter power-down");
   idle_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == RUN && pendIdle && !pendDown && instrEnd && !anyReset) |=> mode == IDLE)
      else $error("Idle not entered at instruction end");
   reset_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(anyReset) |-> coreReset [*8])
      else $error("Reset not held two machine cycles");
   reset_pc_a: assert property (@(posedge clk) disable iff (!rst_b)
      anyReset |=> pcLoad == pmr_pkg::PC_RESET && stack_pointer == pmr_pkg::SP_RESET)
      else $error("Reset did not load pc and stack");
   wdt_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
      wdtFire && !porBusy |=> watchdog_control_reg[pmr_pkg::WDC_WATCHDOG_RESET_FLAG] && coreReset)
      else $error("Watchdog reset flag not set");
   wdt_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == PDOWN && wdtExtClock) |-> !wdtRun)
      else $error("Watchdog runs in power-down");
   pin_c4_a: assert property (@(posedge clk) disable iff (!rst_b)
      (phase != pmr_pkg::STATE_C4) |=> $stable(extReq))
      else $error("Reset pin sampled outside C4");
   rc_clock_a: assert property (@(posedge clk) disable iff (!rst_b)
      (mode == PDOWN && low_power_brownout_sel && !brownout_disable_bit) |=> rcClkSel)
      else $error("Internal RC clock not selected");
   cov_idle_wake: cover property (@(posedge clk) disable iff (!rst_b)
      mode == IDLE ##1 mode == RUN);
   cov_pd_wake: cover property (@(posedge clk) disable iff (!rst_b)
      mode == PDOWN ##1 mode == RUN);
   cov_wdt_reset: cover property (@(posedge clk) disable iff (!rst_b) wdtFire);
   cov_sw_reset: cover property (@(posedge clk) disable iff (!rst_b) swReq);
endmodule
`default_nettype wire

// file: testbench/wake_src_model.sv
// Model of the external reset pin and the wake-up sources
`timescale 1ns/10ps
`default_nettype none
module wake_src_model (
   // Clock and bench commands
   input  wire logic      clk,
   input  wire logic      pinReq,
   input  wire logic [5:0] wakeReq,
   input  wire logic      wakeDrop,
   input  wire logic      wakeIrq,
   // Pins seen by the sequencer
   output logic           resetPin_b,
   output pmr_pkg::wake_s wakePins
);
   logic [3:0] holdCnt;

   // Pins idle inactive before the first command
   initial begin
      resetPin_b = 1'b1;
      wakePins = '0;
      holdCnt = 4'h0;
   end

   // Reset pin stays low for at least two machine cycles
   always @(posedge clk) begin
      if (pinReq) begin
         resetPin_b <= 1'b0;
         holdCnt <= 4'h8;
      end else if (holdCnt != 4'h0) begin
         holdCnt <= holdCnt - 4'h1;
      end else begin
         resetPin_b <= 1'b1;
      end
   end

   // Level sources hold their request until serviced or withdrawn
   always @(posedge clk) begin
      if (wakeIrq || wakeDrop) begin
         wakePins <= '0;
      end else begin
         wakePins <= pmr_pkg::wake_s'(wakePins | wakeReq);
      end
   end
endmodule
`default_nettype wire

// file: testbench/power_mode_reset_ctrl_tb_top.sv
// Self-checking bench for the power-mode and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module power_mode_reset_ctrl_tb_top;
   localparam int GRACE = 8;
   logic              clk, rst_b, instrEnd, pconWrite, auxWrite, porFlagClear, wdtClear;
   logic              wdifClear, ewrstWrite, ewrstData, watchdog_config_bit, wdtExtClock;
   logic              low_power_brownout_sel, brownout_disable_bit, reset_port_high_option;
   logic              wdtTimeout, pinReq, wakeDrop, resetPin_b, cpuClkEn, periphClkEn;
   logic              rcClkSel, coreReset, wdtRun, wakeIrq, porFlag;
   logic [7:0]        pconData, auxData, power_control_reg, watchdog_control_reg;
   logic [7:0]        stack_pointer, portReset, port0_input_disable_reg, d;
   logic [5:0]        wakeReq;
   logic [1:0]        prev;
   logic [15:0]       pcLoad;
   pmr_pkg::irq_cfg_s irqCfg;
   pmr_pkg::wake_s    wakePins;
   pmr_pkg::reset_src_e lastSource;
   int                miscompares, n_compared, cycles, r;

   // Design under test with shortened counts
   power_mode_reset_ctrl #(.HOLD_CYC(2), .GRACE(GRACE), .POR_DLY(4)) i_power_mode_reset_ctrl (
      .clk(clk), .rst_b(rst_b), .resetPin_b(resetPin_b), .wakePins(wakePins),
      .instrEnd(instrEnd), .intTaken(1'b0), .retiDone(1'b0), .pconWrite(pconWrite),
      .pconData(pconData), .auxWrite(auxWrite), .auxData(auxData),
      .porFlagClear(porFlagClear), .wdtClear(wdtClear), .wdifClear(wdifClear),
      .ewrstWrite(ewrstWrite), .ewrstData(ewrstData), .irqCfg(irqCfg),
      .watchdog_config_bit(watchdog_config_bit), .wdtExtClock(wdtExtClock),
      .low_power_brownout_sel(low_power_brownout_sel),
      .brownout_disable_bit(brownout_disable_bit),
      .reset_port_high_option(reset_port_high_option), .wdtTimeout(wdtTimeout),
      .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .rcClkSel(rcClkSel),
      .coreReset(coreReset), .wdtRun(wdtRun), .wakeIrq(wakeIrq),
      .power_control_reg(power_control_reg), .watchdog_control_reg(watchdog_control_reg),
      .porFlag(porFlag), .pcLoad(pcLoad), .stack_pointer(stack_pointer),
      .portReset(portReset), .port0_input_disable_reg(port0_input_disable_reg),
      .lastSource(lastSource));

   // Far side: reset pin and wake sources
   wake_src_model i_wake_src_model (
      .clk(clk), .pinReq(pinReq), .wakeReq(wakeReq), .wakeDrop(wakeDrop),
      .wakeIrq(wakeIrq), .resetPin_b(resetPin_b), .wakePins(wakePins));

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         end_sim();
      end
   end

   // Verdict and end of run
   task automatic end_sim();
      if (miscompares == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: return coreReset;
         default: return cpuClkEn;
      endcase
   endfunction

   // Bounded wait for a level, then compare it
   task automatic waitFor(input int w, input logic lvl, input int lim, input string nm);
      int k;
      k = 0;
      while (pick(w) !== lvl && k < lim) begin
         tick(1);
         k++;
      end
      chk(nm, 16'(lvl), 16'(pick(w)));
   endtask

   // Power control write completed by the end of an instruction
   task automatic enterMode(input logic [7:0] v);
      @(posedge clk);
      pconWrite <= 1'b1;
      pconData <= v;
      instrEnd <= 1'b1;
      @(posedge clk);
      pconWrite <= 1'b0;
      instrEnd <= 1'b0;
      tick(3);
   endtask

   // Expected processor and peripheral clock enables for a mode request
   function automatic logic [15:0] modeClk(input logic [7:0] v);
      return v[1] ? 16'h0 : (v[0] ? 16'h1 : 16'h3);
   endfunction

   // Expected watchdog control bits 2:1 after a reset of the given source
   function automatic logic [15:0] expWdc(input pmr_pkg::reset_src_e s, input logic [1:0] p);
      case (s)
         pmr_pkg::SRC_POR: return 16'h0;
         pmr_pkg::SRC_WDT: return {14'h0, 1'b1, p[0]};
         default: return {14'h0, p};
      endcase
   endfunction

   // Main sequence
   initial begin
      {rst_b, instrEnd, pconWrite, auxWrite, porFlagClear, wdtClear, wdifClear} = '0;
      {ewrstWrite, ewrstData, wdtExtClock, low_power_brownout_sel} = '0;
      {brownout_disable_bit, wdtTimeout, pinReq, wakeDrop} = '0;
      {pconData, auxData, wakeReq, irqCfg} = '0;
      {miscompares, n_compared, cycles} = '0;
      r = $urandom(89378);
      reset_port_high_option = 1'($urandom % 2);
      watchdog_config_bit = 1'($urandom % 2);
      tick(3);
      chk("pcLoad", pmr_pkg::PC_RESET, pcLoad);
      chk("stack_pointer", 16'h07, 16'(stack_pointer));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      waitFor(0, 1'b0, 60, "coreReset");
      chk("porFlag", 16'h1, 16'(porFlag));
      chk("wdc", expWdc(pmr_pkg::SRC_POR, 2'h3), 16'(watchdog_control_reg[2:1]));
      if (reset_port_high_option) chk("portReset", 16'hff, 16'(portReset));
      chk("p0dis", 16'h0, 16'(port0_input_disable_reg));
      @(posedge clk);
      porFlagClear <= 1'b1;
      @(posedge clk);
      porFlagClear <= 1'b0;
      tick(2);
      chk("porFlag", 16'h0, 16'(porFlag));
      // Idle entry and wake by an enabled interrupt
      enterMode(8'h01);
      chk("clkEn", modeClk(8'h01), {cpuClkEn, periphClkEn});
      @(posedge clk);
      irqCfg.anyEnabled <= 1'b1;
      waitFor(1, 1'b1, 12, "cpuClkEn");
      chk("pconIdle", 16'h0, 16'(power_control_reg[0]));
      @(posedge clk);
      irqCfg.anyEnabled <= 1'b0;
      // Power-down woken by keypad, brownout and each comparator in turn
      r = $urandom % 4;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         low_power_brownout_sel <= 1'($urandom % 2);
         brownout_disable_bit <= 1'($urandom % 2);
         wdtExtClock <= 1'b1;
         d = ($urandom % 2) ? 8'h03 : 8'h02;
         enterMode(d);
         chk("clkEn", modeClk(d), {cpuClkEn, periphClkEn});
         chk("rcClkSel", 16'(low_power_brownout_sel & ~brownout_disable_bit), 16'(rcClkSel));
         chk("wdtRun", 16'h0, 16'(wdtRun));
         @(posedge clk);
         wakeReq <= 6'h1 << ((i + r) % 4);
         @(posedge clk);
         wakeReq <= 6'h0;
         waitFor(1, 1'b1, 12, "cpuClkEn");
         chk("wakePins", 16'h0, 16'(wakePins));
      end
      // External pin refused in edge mode, accepted in level mode
      @(posedge clk);
      irqCfg <= '{globalEn: 1'b1, int0En: 1'b1, default: 1'b0};
      enterMode(8'h02);
      @(posedge clk);
      wakeReq <= 6'h20;
      @(posedge clk);
      wakeReq <= 6'h0;
      tick(12);
      chk("cpuClkEn", 16'h0, 16'(cpuClkEn));
      @(posedge clk);
      irqCfg.int0Level <= 1'b1;
      waitFor(1, 1'b1, 12, "cpuClkEn");
      @(posedge clk);
      wakeDrop <= 1'b1;
      irqCfg <= '0;
      @(posedge clk);
      wakeDrop <= 1'b0;
      // Watchdog time-out without and with reset enabled
      for (int e = 0; e < 2; e++) begin
         @(posedge clk);
         ewrstWrite <= 1'b1;
         wdtClear <= 1'b1;
         ewrstData <= 1'(e);
         @(posedge clk);
         ewrstWrite <= 1'b0;
         wdtClear <= 1'b0;
         wdtTimeout <= 1'b1;
         @(posedge clk);
         wdtTimeout <= 1'b0;
         tick(GRACE - 4);
         prev = watchdog_control_reg[2:1];
         chk("wdif", 16'h1, 16'(watchdog_control_reg[3]));
         chk("coreReset", 16'h0, 16'(coreReset));
         waitFor(0, 1'(e), 12, "coreReset");
      end
      waitFor(0, 1'b0, 30, "coreReset");
      chk("wdc", expWdc(pmr_pkg::SRC_WDT, prev), 16'(watchdog_control_reg[2:1]));
      chk("lastSource", 16'(pmr_pkg::SRC_WDT), 16'(lastSource));
      // External reset out of idle or power-down
      d = ($urandom % 2) ? 8'h01 : 8'h02;
      enterMode(d);
      prev = watchdog_control_reg[2:1];
      @(posedge clk);
      pinReq <= 1'b1;
      @(posedge clk);
      pinReq <= 1'b0;
      waitFor(0, 1'b1, 12, "coreReset");
      chk("pcLoad", pmr_pkg::PC_RESET, pcLoad);
      waitFor(0, 1'b0, 30, "coreReset");
      chk("wdc", expWdc(pmr_pkg::SRC_EXT, prev), 16'(watchdog_control_reg[2:1]));
      chk("porFlag", 16'h0, 16'(porFlag));
      chk("clkEn", 16'h3, {cpuClkEn, periphClkEn});
      // Software reset
      @(posedge clk);
      auxWrite <= 1'b1;
      auxData <= 8'h08;
      @(posedge clk);
      auxWrite <= 1'b0;
      waitFor(0, 1'b1, 4, "coreReset");
      chk("stack_pointer", 16'h07, 16'(stack_pointer));
      waitFor(0, 1'b0, 30, "coreReset");
      chk("lastSource", 16'(pmr_pkg::SRC_SW), 16'(lastSource));
      end_sim();
   end
endmodule
`default_nettype wire
